// ---- core/qbsp_pkg.sv ----
// ************************************************************
// Shared constants and types
// ************************************************************
package qbsp_pkg;

    localparam int ADDR_W         = 20;
    localparam int DATA_W         = 18;
    localparam int LANE_W         = 9;
    localparam int MASK_W         = 2;
    localparam int BURST_LEN      = 4;
    localparam int ARRAY_AW       = 8;
    localparam int LOG_W          = ADDR_W + 1;
    localparam int LOG_KIND_BIT   = ADDR_W;
    localparam int LOG_DEPTH      = 16;
    localparam int CLK_PERIOD_NS  = 40;

    localparam logic [MASK_W-1:0] MASK_NONE_N = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RESET  = 18'h00000;
    localparam logic              OE_OFF_N    = 1'b1;
    localparam logic              LOG_IS_READ = 1'b0;
    localparam logic              LOG_IS_WR   = 1'b1;

    typedef logic [ADDR_W-1:0] qbsp_addr_t;
    typedef logic [DATA_W-1:0] qbsp_data_t;
    typedef logic [MASK_W-1:0] qbsp_mask_t;

endpackage

// ---- core/qbsp_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module qbsp_fifo
    import qbsp_pkg::*;
#(
    parameter int WIDTH = LOG_W,
    parameter int DEPTH = LOG_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready = (count_reg != (PW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = (count_reg != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + (PW+1)'(1);
        end else if (pop && !push) begin
            count_reg <= count_reg - (PW+1)'(1);
        end
    end

    // Output stage is a register so the consumer sees flop outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= store[rd_ptr_reg];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- core/qbsp_port.sv ----
// Behaviour
// - A read starts when read select is low at a rising link clock edge, taking that edge's address.
// - A write starts when write select is low at a rising link clock edge, taking that edge's address.
// - Every read and write moves exactly four beats, never any other count.
// - Read beats leave at the falling edge 1.5, rising 2.0, falling 2.5 and rising 3.0 cycles on.
// - A second read or write on the very next rising edge is dropped and only the first runs.
// - With both selects low right after an idle edge, the read runs and the write is dropped.
// - With both selects high nothing starts; outside running bursts write data is ignored and read outputs float.
// - Each write beat has two active-low lane masks, lane 0 for bits 0-8, lane 1 for 9-17; both high skips it.
// - Burst addresses run linearly as start plus 0, 1, 2 and 3.
// - A read fetching on the commit edge of the most recent buffered write returns the buffered data.
// - An idle edge never cuts short a read burst already running.
// - With write select high at a rising edge nothing is stored for that slot.
`timescale 1ns/1ps
`default_nettype none
module qbsp_port
    import qbsp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              k_clk,
    input  wire logic              rd_sel_n,
    input  wire logic              wr_sel_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] d,
    input  wire logic              byte_mask_lane0_n,
    input  wire logic              byte_mask_lane1_n,
    output logic      [DATA_W-1:0] q_k,
    output logic                   q_k_oe_n,
    output logic      [DATA_W-1:0] q_kn,
    output logic                   q_kn_oe_n,
    output logic                   log_valid,
    output logic      [LOG_W-1:0]  log_word,
    input  wire logic              log_ready
);
    // ************************************************************
    // Link reset
    // ************************************************************
    logic k_rst_s1;
    logic k_rst_b_sync;

    always_ff @(posedge k_clk or negedge rst_b) begin
        if (!rst_b) begin
            k_rst_s1     <= 1'b0;
            k_rst_b_sync <= 1'b0;
        end else begin
            k_rst_s1     <= 1'b1;
            k_rst_b_sync <= k_rst_s1;
        end
    end

    // ************************************************************
    // Command decode
    // ************************************************************
    logic       s1_reg, s2_reg, s3_reg;
    logic       w1_reg, w2_reg, w3_reg;
    logic       nop_prev_reg;
    logic       rd_accept;
    logic       wr_accept;
    qbsp_addr_t rd_addr_reg;
    qbsp_addr_t wr_addr_reg;
    qbsp_addr_t cm_addr_reg;

    assign rd_accept = !rd_sel_n && !s1_reg;
    assign wr_accept = !wr_sel_n && !w1_reg && !(nop_prev_reg && !rd_sel_n);

    always_ff @(posedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            nop_prev_reg <= 1'b0;
        end else begin
            nop_prev_reg <= rd_sel_n && wr_sel_n;
        end
    end

    // Read sequencer: one stage flag per rising edge of the burst
    always_ff @(posedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            s1_reg      <= 1'b0;
            s2_reg      <= 1'b0;
            s3_reg      <= 1'b0;
            rd_addr_reg <= '0;
        end else begin
            s1_reg <= rd_accept;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (rd_accept) begin
                rd_addr_reg <= addr;
            end
        end
    end

    // Write sequencer, independent of the read one
    always_ff @(posedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            w1_reg      <= 1'b0;
            w2_reg      <= 1'b0;
            w3_reg      <= 1'b0;
            wr_addr_reg <= '0;
            cm_addr_reg <= '0;
        end else begin
            w1_reg <= wr_accept;
            w2_reg <= w1_reg;
            w3_reg <= w2_reg;
            if (wr_accept) begin
                wr_addr_reg <= addr;
            end
            if (w2_reg) begin
                cm_addr_reg <= wr_addr_reg;
            end
        end
    end

    // ************************************************************
    // Write beat capture
    // ************************************************************
    qbsp_data_t wb0_d_reg, wb1_d_reg, wb2_d_reg, wb3_d_reg;
    qbsp_mask_t wb0_m_reg, wb1_m_reg, wb2_m_reg, wb3_m_reg;

    always_ff @(posedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            wb0_d_reg <= DATA_RESET;
            wb2_d_reg <= DATA_RESET;
            wb0_m_reg <= MASK_NONE_N;
            wb2_m_reg <= MASK_NONE_N;
        end else begin
            if (w1_reg) begin
                wb0_d_reg <= d;
                wb0_m_reg <= {byte_mask_lane1_n, byte_mask_lane0_n};
            end
            if (w2_reg) begin
                wb2_d_reg <= d;
                wb2_m_reg <= {byte_mask_lane1_n, byte_mask_lane0_n};
            end
        end
    end

    always_ff @(negedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            wb1_d_reg <= DATA_RESET;
            wb3_d_reg <= DATA_RESET;
            wb1_m_reg <= MASK_NONE_N;
            wb3_m_reg <= MASK_NONE_N;
        end else begin
            if (w2_reg) begin
                wb1_d_reg <= d;
                wb1_m_reg <= {byte_mask_lane1_n, byte_mask_lane0_n};
            end
            if (w3_reg) begin
                wb3_d_reg <= d;
                wb3_m_reg <= {byte_mask_lane1_n, byte_mask_lane0_n};
            end
        end
    end

    // ************************************************************
    // Array and forwarding
    // ************************************************************
    qbsp_data_t array_mem [2**ARRAY_AW];

    function automatic qbsp_data_t lane_merge(input qbsp_data_t old_w,
                                              input qbsp_data_t new_w,
                                              input qbsp_mask_t m_n);
        qbsp_data_t w;
        w = old_w;
        if (!m_n[0]) begin
            w[LANE_W-1:0] = new_w[LANE_W-1:0];
        end
        if (!m_n[1]) begin
            w[DATA_W-1:LANE_W] = new_w[DATA_W-1:LANE_W];
        end
        return w;
    endfunction

    function automatic qbsp_data_t fetch_word(input qbsp_addr_t a);
        qbsp_addr_t off;
        qbsp_data_t w;
        off = a - cm_addr_reg;
        w   = array_mem[a[ARRAY_AW-1:0]];
        // Burst still in the buffer on its commit edge
        if (w3_reg && off < ADDR_W'(BURST_LEN)) begin
            unique case (off[1:0])
                2'h0: w = lane_merge(w, wb0_d_reg, wb0_m_reg);
                2'h1: w = lane_merge(w, wb1_d_reg, wb1_m_reg);
                2'h2: w = lane_merge(w, wb2_d_reg, wb2_m_reg);
                2'h3: w = lane_merge(w, wb3_d_reg, wb3_m_reg);
            endcase
        end
        return w;
    endfunction

    always_ff @(posedge k_clk) begin
        if (w3_reg) begin
            array_mem[cm_addr_reg[ARRAY_AW-1:0]] <=
                lane_merge(array_mem[cm_addr_reg[ARRAY_AW-1:0]], wb0_d_reg, wb0_m_reg);
            array_mem[ARRAY_AW'(cm_addr_reg + ADDR_W'(1))] <=
                lane_merge(array_mem[ARRAY_AW'(cm_addr_reg + ADDR_W'(1))], wb1_d_reg, wb1_m_reg);
            array_mem[ARRAY_AW'(cm_addr_reg + ADDR_W'(2))] <=
                lane_merge(array_mem[ARRAY_AW'(cm_addr_reg + ADDR_W'(2))], wb2_d_reg, wb2_m_reg);
            array_mem[ARRAY_AW'(cm_addr_reg + ADDR_W'(3))] <=
                lane_merge(array_mem[ARRAY_AW'(cm_addr_reg + ADDR_W'(3))], wb3_d_reg, wb3_m_reg);
        end
    end

    // ************************************************************
    // Read beat output
    // ************************************************************
    qbsp_data_t even_reg;
    qbsp_data_t odd_reg;

    always_ff @(posedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            even_reg <= DATA_RESET;
            odd_reg  <= DATA_RESET;
        end else if (s1_reg) begin
            even_reg <= fetch_word(rd_addr_reg);
            odd_reg  <= fetch_word(rd_addr_reg + ADDR_W'(1));
        end else if (s2_reg) begin
            even_reg <= fetch_word(rd_addr_reg + ADDR_W'(2));
            odd_reg  <= fetch_word(rd_addr_reg + ADDR_W'(3));
        end
    end

    always_ff @(posedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            q_k      <= DATA_RESET;
            q_k_oe_n <= OE_OFF_N;
        end else if (s2_reg || s3_reg) begin
            q_k      <= odd_reg;
            q_k_oe_n <= 1'b0;
        end else begin
            q_k_oe_n <= OE_OFF_N;
        end
    end

    always_ff @(negedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            q_kn      <= DATA_RESET;
            q_kn_oe_n <= OE_OFF_N;
        end else if (s2_reg || s3_reg) begin
            q_kn      <= even_reg;
            q_kn_oe_n <= 1'b0;
        end else begin
            q_kn_oe_n <= OE_OFF_N;
        end
    end

    // ************************************************************
    // Command log crossing
    // ************************************************************
    logic             req_tgl_reg;
    logic [LOG_W-1:0] xword_reg;
    logic             ack_s1, ack_s2;
    logic             req_s1, req_s2;
    logic             seen_tgl_reg;
    logic             fifo_in_ready;
    logic             log_push;

    always_ff @(posedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= seen_tgl_reg;
            ack_s2 <= ack_s1;
        end
    end

    // Commands arriving while a word is in flight are not logged
    always_ff @(posedge k_clk or negedge k_rst_b_sync) begin
        if (!k_rst_b_sync) begin
            req_tgl_reg <= 1'b0;
            xword_reg   <= '0;
        end else if (req_tgl_reg == ack_s2 && (rd_accept || wr_accept)) begin
            req_tgl_reg <= !req_tgl_reg;
            xword_reg   <= {(rd_accept ? LOG_IS_READ : LOG_IS_WR), addr};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            req_s1 <= req_tgl_reg;
            req_s2 <= req_s1;
        end
    end

    assign log_push = (req_s2 != seen_tgl_reg) && fifo_in_ready;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_tgl_reg <= 1'b0;
        end else if (log_push) begin
            seen_tgl_reg <= req_s2;
        end
    end

    qbsp_fifo #(
        .WIDTH (LOG_W),
        .DEPTH (LOG_DEPTH)
    ) u_log_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (log_push),
        .in_data   (xword_reg),
        .in_ready  (fifo_in_ready),
        .out_valid (log_valid),
        .out_data  (log_word),
        .out_ready (log_ready)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge k_clk);
    endclocking
    default disable iff (!k_rst_b_sync);

    chk_rd_beat_time: assert property (rd_accept |-> ##3 !q_k_oe_n ##1 !q_k_oe_n)
        else $error("read beats on rising edge out of time");
    chk_rd_first_beat: assert property ((rd_accept && !s2_reg) |->
        ##1 q_kn_oe_n ##1 !q_kn_oe_n ##1 !q_kn_oe_n)
        else $error("first read beat not at falling edge 1.5");
    chk_rd_b2b_drop: assert property (rd_accept |=> !rd_accept)
        else $error("back to back read not dropped");
    chk_wr_b2b_drop: assert property (wr_accept |=> !wr_accept)
        else $error("back to back write not dropped");
    chk_read_wins: assert property ((nop_prev_reg && !rd_sel_n && !wr_sel_n) |-> rd_accept && !wr_accept)
        else $error("write not dropped after idle edge");
    chk_idle_none: assert property ((rd_sel_n && wr_sel_n) |-> !rd_accept && !wr_accept)
        else $error("command taken while both selects high");
    chk_burst_four: assert property (rd_accept |=> s1_reg ##1 s2_reg ##1 s3_reg)
        else $error("read burst not four beats long");
    chk_wr_commit: assert property (wr_accept |-> ##3 w3_reg)
        else $error("write not committed on third cycle");
    chk_nop_no_cut: assert property ((s2_reg && rd_sel_n) |=> !q_k_oe_n ##1 !q_k_oe_n)
        else $error("idle edge cut a read burst");
    chk_read_forward: assert property ((s1_reg && w3_reg && rd_addr_reg == cm_addr_reg
        && wb0_m_reg == 2'h0) |=> even_reg == $past(wb0_d_reg))
        else $error("buffered write not forwarded");
    chk_lane0_store: assert property ((w3_reg && !wb0_m_reg[0])
        |=> array_mem[$past(cm_addr_reg[ARRAY_AW-1:0])][LANE_W-1:0]
            == $past(wb0_d_reg[LANE_W-1:0]))
        else $error("lane 0 not stored");

    cov_read: cover property (rd_accept ##2 rd_accept);
    cov_write: cover property (wr_accept ##2 wr_accept);
    cov_overlap: cover property (rd_accept && wr_accept);
    cov_forward: cover property (s1_reg && w3_reg && rd_addr_reg == cm_addr_reg);
endmodule
`default_nettype wire

// ---- tb/qbsp_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Memory controller model: plays queued commands and beats
// ************************************************************
module qbsp_ctrl_model
    import qbsp_pkg::*;
(
    input  wire logic              k_clk,
    output logic                   rd_sel_n,
    output logic                   wr_sel_n,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] d,
    output logic                   byte_mask_lane0_n,
    output logic                   byte_mask_lane1_n
);
    logic [ADDR_W+1:0] cmd_q[$];
    logic [DATA_W+2:0] beat_q[$];
    logic [ADDR_W+1:0] c;
    logic [DATA_W+2:0] b;

    initial begin
        rd_sel_n          = 1'b1;
        wr_sel_n          = 1'b1;
        addr              = '0;
        d                 = '0;
        byte_mask_lane0_n = 1'b1;
        byte_mask_lane1_n = 1'b1;
    end

    // Commands change after the falling edge; idle cycles scramble the address
    always @(negedge k_clk) begin
        c = (cmd_q.size() != 0) ? cmd_q.pop_front() : {2'h3, addr};
        rd_sel_n <= c[ADDR_W+1];
        wr_sel_n <= c[ADDR_W];
        addr     <= (&c[ADDR_W+1:ADDR_W]) ? ~addr : c[ADDR_W-1:0];
    end

    // One beat slot per clock edge; a released slot shows inverted lines
    always @(k_clk) begin
        b = (beat_q.size() != 0) ? beat_q.pop_front() : '0;
        if (b[DATA_W+2]) begin
            d                 <= b[DATA_W-1:0];
            byte_mask_lane0_n <= b[DATA_W];
            byte_mask_lane1_n <= b[DATA_W+1];
        end else begin
            d                 <= ~d;
            byte_mask_lane0_n <= ~byte_mask_lane0_n;
            byte_mask_lane1_n <= ~byte_mask_lane1_n;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_quad_burst4_sram_port_protocol.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_quad_burst4_sram_port_protocol
    import qbsp_pkg::*;
;
    localparam int NP = 14;
    logic              clk;
    logic              k_clk;
    logic              rst_b;
    logic              rd_sel_n;
    logic              wr_sel_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d;
    logic              byte_mask_lane0_n;
    logic              byte_mask_lane1_n;
    logic [DATA_W-1:0] q_k;
    logic              q_k_oe_n;
    logic [DATA_W-1:0] q_kn;
    logic              q_kn_oe_n;
    logic              log_valid;
    logic [LOG_W-1:0]  log_word;
    logic              log_ready;
    logic [ADDR_W+1:0] pc[NP];
    logic [DATA_W+2:0] pb[2*NP];
    logic [DATA_W:0]   capn[NP];
    logic [DATA_W:0]   capp[NP];
    qbsp_data_t        ex[4];
    logic [LOG_W-1:0]  first_w;
    int                n_errors;
    int                compares;
    int                n_log;

    qbsp_port DUT (.clk(clk), .rst_b(rst_b), .k_clk(k_clk), .rd_sel_n(rd_sel_n),
        .wr_sel_n(wr_sel_n), .addr(addr), .d(d), .byte_mask_lane0_n(byte_mask_lane0_n),
        .byte_mask_lane1_n(byte_mask_lane1_n), .q_k(q_k), .q_k_oe_n(q_k_oe_n), .q_kn(q_kn),
        .q_kn_oe_n(q_kn_oe_n), .log_valid(log_valid), .log_word(log_word),
        .log_ready(log_ready));

    qbsp_ctrl_model u_ctrl (.k_clk(k_clk), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
        .addr(addr), .d(d), .byte_mask_lane0_n(byte_mask_lane0_n),
        .byte_mask_lane1_n(byte_mask_lane1_n));

    // ************************************************************
    // Clocks and log sink
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Link clock runs free, never stopped mid-burst
    initial begin
        k_clk = 1'b0;
        #7;
        forever #32 k_clk = ~k_clk;
    end

    always @(posedge clk) begin
        if (log_valid === 1'b1 && log_ready === 1'b1) begin
            if (n_log == 0) first_w = log_word;
            n_log = n_log + 1;
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [LOG_W-1:0] got, input logic [LOG_W-1:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic plan_clear();
        for (int i = 0; i < NP; i++) pc[i] = {2'h3, {ADDR_W{1'b0}}};
        for (int i = 0; i < 2*NP; i++) pb[i] = '0;
    endtask

    task automatic plan_rd(input int k, input qbsp_addr_t a);
        pc[k][ADDR_W+1]   = 1'b0;
        pc[k][ADDR_W-1:0] = a;
    endtask

    task automatic plan_wr(input int k, input qbsp_addr_t a);
        pc[k][ADDR_W]     = 1'b0;
        pc[k][ADDR_W-1:0] = a;
    endtask

    // Beat i of a write taken at slot k goes out on half-slot 2k+2+i
    task automatic plan_beats(input int k, input qbsp_data_t base, input logic [7:0] msk);
        for (int i = 0; i < 4; i++) pb[2*k+2+i] = {1'b1, msk[2*i+:2], qbsp_data_t'(base + 18'(i))};
    endtask

    task automatic run_plan();
        @(posedge k_clk);
        #1;
        for (int i = 0; i < NP; i++) u_ctrl.cmd_q.push_back(pc[i]);
        for (int i = 0; i < 2*NP; i++) u_ctrl.beat_q.push_back(pb[i]);
        for (int j = 0; j < NP; j++) begin
            @(negedge k_clk);
            #1 capn[j] = {q_kn_oe_n, q_kn};
            @(posedge k_clk);
            #1 capp[j] = {q_k_oe_n, q_k};
        end
    endtask

    task automatic fill_ex(input qbsp_data_t base);
        for (int i = 0; i < 4; i++) ex[i] = qbsp_data_t'(base + 18'(i));
    endtask

    function automatic qbsp_data_t merge(input qbsp_data_t o, input qbsp_data_t n,
                                         input logic [1:0] m);
        merge = {m[1] ? o[DATA_W-1:LANE_W] : n[DATA_W-1:LANE_W],
                 m[0] ? o[LANE_W-1:0] : n[LANE_W-1:0]};
    endfunction

    task automatic set_masked();
        for (int i = 0; i < 4; i++)
            ex[i] = merge(18'h2AAA0 + 18'(i), 18'h15550 + 18'(i), 2'(8'h36 >> (2*i)));
    endtask

    task automatic chk_read(input int k, input string what);
        for (int i = 0; i < 2; i++) begin
            check(LOG_W'(capn[k+2+i]), LOG_W'({1'b0, ex[2*i]}), what);
            check(LOG_W'(capp[k+2+i]), LOG_W'({1'b0, ex[2*i+1]}), what);
        end
    endtask

    task automatic chk_off(input int j, input string what);
        check(LOG_W'({capn[j][DATA_W], capp[j][DATA_W]}), LOG_W'(2'h3), what);
    endtask

    task automatic wait_drain();
        int i;
        i = 0;
        while (log_valid !== 1'b0 && i < 400) begin
            @(negedge clk);
            i++;
        end
        if (i == 400) begin
            n_errors++;
            $display("[FAIL] %0t ns: log stream never drained", $time);
            print_verdict();
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic wr_rd_basic();
        n_log = 0;
        plan_clear();
        plan_wr(0, 20'h000FE);
        plan_beats(0, 18'h12340, 8'h00);
        plan_rd(2, 20'h000FE);
        run_plan();
        fill_ex(18'h12340);
        chk_read(2, "burst read back");
        chk_off(3, "idle before burst");
        chk_off(6, "idle after burst");
        check(first_w, {LOG_IS_WR, 20'h000FE}, "first log word");
    endtask

    task automatic masked_write();
        plan_clear();
        plan_wr(0, 20'h00040);
        plan_beats(0, 18'h2AAA0, 8'h00);
        plan_wr(2, 20'h00040);
        plan_beats(2, 18'h15550, 8'h36);
        plan_rd(6, 20'h00040);
        run_plan();
        set_masked();
        chk_read(6, "lane masked write");
    endtask

    // Second read and second write one edge after the first; stray beats with no write
    task automatic back_to_back();
        plan_clear();
        plan_wr(0, 20'h00080);
        plan_beats(0, 18'h01110, 8'h00);
        plan_wr(2, 20'h000C0);
        plan_beats(2, 18'h02220, 8'h00);
        plan_wr(3, 20'h00080);
        plan_beats(4, 18'h3FFF0, 8'h00);
        plan_rd(6, 20'h00080);
        plan_rd(7, 20'h000C0);
        run_plan();
        fill_ex(18'h01110);
        chk_read(6, "refused write kept old data");
        chk_off(10, "refused read stays silent");
    endtask

    task automatic both_selects();
        plan_clear();
        plan_wr(0, 20'h00104);
        plan_beats(0, 18'h04440, 8'h00);
        plan_rd(3, 20'h00104);
        plan_wr(3, 20'h00104);
        plan_beats(3, 18'h3C3C0, 8'h00);
        plan_rd(6, 20'h00104);
        run_plan();
        fill_ex(18'h04440);
        chk_read(3, "read wins after idle");
        chk_read(6, "losing write not stored");
    endtask

    task automatic overlap();
        plan_clear();
        plan_rd(0, 20'h00040);
        plan_wr(1, 20'h00140);
        plan_beats(1, 18'h05550, 8'h00);
        plan_rd(2, 20'h00080);
        plan_rd(5, 20'h00140);
        run_plan();
        set_masked();
        chk_read(0, "read beside write");
        fill_ex(18'h01110);
        chk_read(2, "seamless second read");
        fill_ex(18'h05550);
        chk_read(5, "overlapped write stored");
    endtask

    task automatic log_fill();
        wait_drain();
        @(negedge clk);
        log_ready = 1'b0;
        n_log     = 0;
        for (int i = 0; i < 20; i++) begin
            plan_clear();
            plan_rd(0, qbsp_addr_t'(20'h00200 + 20'(i)));
            run_plan();
        end
        check(LOG_W'(log_valid), LOG_W'(1'b1), "log held while stalled");
        @(negedge clk);
        log_ready = 1'b1;
        wait_drain();
        check(LOG_W'(n_log >= LOG_DEPTH + 1 && n_log <= LOG_DEPTH + 2), LOG_W'(1'b1), "log kept");
        check(first_w, {LOG_IS_READ, 20'h00200}, "oldest log word");
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst_b     = 1'b0;
        log_ready = 1'b1;
        n_errors  = 0;
        compares  = 0;
        n_log     = 0;
        repeat (6) @(negedge clk);
        check(LOG_W'({q_k_oe_n, q_kn_oe_n, log_valid}), LOG_W'(3'h6), "reset state");
        rst_b = 1'b1;
        repeat (4) @(posedge k_clk);
        wr_rd_basic();
        masked_write();
        back_to_back();
        both_selects();
        overlap();
        log_fill();
        print_verdict();
    end
endmodule
`default_nettype wire
